// file: pkg/spcs_regs.svh
`ifndef SPCS_REGS_SVH
`define SPCS_REGS_SVH

// ============================================================
// Register map (socket B sits 0x800 above socket A)
`define SPCS_SOCK_SEL_BIT     11
`define SPCS_EVENT_OFF        11'h000
`define SPCS_MASK_OFF         11'h004
`define SPCS_PRESENT_OFF      11'h008
`define SPCS_CONTROL_OFF      11'h010
`define SPCS_EXT_BASE         12'h900
`define SPCS_MISC3_IDX        12'h025
`define SPCS_MISC3_RESET      8'h03

// ============================================================
// Field positions
`define SPCS_EVT_DETECT_BIT   1
`define SPCS_M3_PWRMODE_BIT   2
`define SPCS_M3_SUSPEN_BIT    4
`define SPCS_INT_MODE_PCI     2'h3
`define SPCS_CTL_VPP_LSB      0
`define SPCS_CTL_VCC_LSB      4
`define SPCS_PS_CD1_BIT       0
`define SPCS_PS_CD2_BIT       1
`define SPCS_PS_PWRCYC_BIT    3
`define SPCS_PS_C16_BIT       4
`define SPCS_PS_CB_BIT        5
`define SPCS_PS_NOTCARD_BIT   7
`define SPCS_PS_5V_BIT        10
`define SPCS_PS_3V_BIT        11
`define SPCS_PS_XV_BIT        12
`define SPCS_PS_YV_BIT        13

// ============================================================
// Power switch link
`define SPCS_SMB_ADDR         7'h2a
`define SPCS_SERIAL_BITS      5'h08
`define SPCS_SMB_BITS         5'h12

// ============================================================
// Timing
`define SPCS_CLK_MHZ          200
`define SPCS_SETTLE_NS        1000
`define SPCS_SETTLE_CYC       ((`SPCS_SETTLE_NS * `SPCS_CLK_MHZ + 999) / 1000)

`endif

// file: pkg/spcs_pkg.sv
package spcs_pkg;

    // ============================================================
    // Power switch link sequencer
    typedef enum logic [4:0]
    {
        SPCS_IDLE  = 5'h01,
        SPCS_START = 5'h02,
        SPCS_SHIFT = 5'h04,
        SPCS_STOP  = 5'h08,
        SPCS_LATCH = 5'h10
    } spcs_link_state_t;

    // ============================================================
    // Sense interrogation phases
    typedef enum logic [2:0]
    {
        SPCS_PH_REST = 3'h1,
        SPCS_PH_VS1  = 3'h2,
        SPCS_PH_VS2  = 3'h4
    } spcs_phase_t;

endpackage

// file: rtl/spcs_top.sv
`timescale 1ns/10ps
`include "spcs_regs.svh"
// Behaviour
// - Suspend pin acts only while suspend enable bit 4 of index 25h is set.
// - In suspend all outputs float except bus request, held driven high.
// - All state is kept through stopped clock and suspend while reset is inactive.
// - ISA interrupts are shown only after requesting clock restart via clock-run.
// - PCI interrupts and ring indicate assert without needing the bus clock.
// - Latch pin level at reset picks power mode; software overrides through bit 2.
// - Serial mode uses reference clock, serial data and a latch strobe.
// - A slow reference clock serves the device and clocks the power switch.
// - External-hardware serial mode behaves exactly like serial switch mode.
// - SMBus mode drives power over two-wire data and clock pins.
// - Card removal turns VCC and VPP off without software.
// - A management interrupt can report card removal.
// - Socket power stays off after reset and while no card is present.
// - A change in card presence can raise a management interrupt when enabled.
// - Card type and voltage decode from detect and sense pins.
// - Type and voltages, x.x and y.y included, report in present state.
// - Decoding assumes a low-voltage keyed socket.
module spcs_top
(
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic [11:0] REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [31:0] REG_WDATA,
    output logic      [31:0] REG_RDATA,
    input  wire logic        SUSPEND_REQUEST_PIN_N,
    input  wire logic        SLOW_CLK,
    input  wire logic [1:0]  CARD_DETECT_ONE_N,
    input  wire logic [1:0]  CARD_DETECT_TWO_N,
    input  wire logic [1:0]  VOLTAGE_SENSE_ONE_IN,
    output logic      [1:0]  VOLTAGE_SENSE_ONE_OUT,
    output logic      [1:0]  VOLTAGE_SENSE_ONE_OE,
    input  wire logic [1:0]  VOLTAGE_SENSE_TWO_IN,
    output logic      [1:0]  VOLTAGE_SENSE_TWO_OUT,
    output logic      [1:0]  VOLTAGE_SENSE_TWO_OE,
    output logic             POWER_SERIAL_DATA_OUT,
    output logic             POWER_SERIAL_DATA_OE,
    input  wire logic        POWER_LATCH_STROBE_IN,
    output logic             POWER_LATCH_STROBE_OUT,
    output logic             POWER_LATCH_STROBE_OE,
    input  wire logic        CLKRUN_N_IN,
    output logic             CLKRUN_N_OUT,
    output logic             CLKRUN_N_OE,
    output logic             INTA_N_OUT,
    output logic             INTA_N_OE,
    output logic             INTB_N_OUT,
    output logic             INTB_N_OE,
    output logic             ISA_IRQ_OUT,
    output logic             ISA_IRQ_OE,
    input  wire logic [1:0]  RING_IN_N,
    output logic             RING_INDICATE_OUT_N,
    output logic             RING_INDICATE_OE,
    output logic             BUS_REQUEST_N_OUT,
    output logic             BUS_REQUEST_N_OE
);

    localparam logic [7:0] SETTLE_LAST = 8'(`SPCS_SETTLE_CYC - 1);

    // ============================================================
    // Card decode: {yv, xv, 3v, 5v, notacard, cardbus, card16, present}
    function automatic logic [7:0] decode_card(input logic [3:0] rest, input logic [1:0] a, input logic [1:0] b);
        logic l11;
        logic l21;
        logic l22;
        logic l12;
        logic vs1g;
        logic vs2g;
        l11  = rest[2] & ~a[0];
        l21  = rest[3] & ~a[1];
        l22  = rest[3] & ~b[1];
        l12  = rest[2] & ~b[0];
        vs1g = ~rest[0];
        vs2g = ~rest[1];
        decode_card = 8'h00;
        if (~rest[3] & ~rest[2])
        begin
            case ({vs2g, vs1g})
                2'h0:    decode_card = 8'h13;
                2'h3:    decode_card = 8'h63;
                2'h2:    decode_card = 8'h43;
                default: decode_card = 8'h09;
            endcase
        end
        else if (l11)
            decode_card = vs2g ? 8'h09 : 8'h25;
        else if (l22)
            decode_card = vs1g ? 8'h65 : 8'h45;
        else if (l21)
            decode_card = vs2g ? 8'he5 : 8'h85;
        else if (l12)
            decode_card = vs1g ? 8'h09 : 8'hc5;
    endfunction

    // ============================================================
    // Declarations
    logic [13:0]                 sync1_r;
    logic [13:0]                 sync2_r;
    logic                        slow_prev_r;
    logic                        slow_rise;
    logic                        slow_fall;
    logic                        suspended;
    logic [7:0]                  misc3_r;
    logic [1:0]                  evt_r;
    logic [1:0]                  mask_r;
    logic [1:0]                  vpp_r [2];
    logic [1:0]                  vcc_r [2];
    logic [3:0]                  rest_r [2];
    logic [1:0]                  snap_a_r [2];
    logic [1:0]                  snap_b_r [2];
    logic [7:0]                  info_r [2];
    logic [7:0]                  info_nxt [2];
    logic [3:0]                  eff_pwr [2];
    logic [7:0]                  settle_r;
    spcs_pkg::spcs_phase_t       phase_r;
    spcs_pkg::spcs_link_state_t  link_r;
    logic [17:0]                 sh_r;
    logic [4:0]                  bits_r;
    logic [7:0]                  sent_r;
    logic [7:0]                  pwr_word;
    logic                        smb_mode;
    logic                        line_data_r;
    logic                        line_clk_r;
    logic                        line_latch_r;
    logic [1:0]                  irq_req;
    logic [1:0]                  cd1_n_s;
    logic [1:0]                  cd2_n_s;
    logic [1:0]                  vs1_s;
    logic [1:0]                  vs2_s;
    logic [1:0]                  ring_n_s;
    logic                        clkrun_s;
    logic                        sock;
    logic [10:0]                 off;

    // ============================================================
    // Input synchronisers; the reference clock is sampled like any pin
    // reference clock sampled
    always_ff @(posedge CLOCK)
    begin
        if (CE)
        begin
            sync1_r     <= {SUSPEND_REQUEST_PIN_N, SLOW_CLK, CARD_DETECT_ONE_N, CARD_DETECT_TWO_N,
                            VOLTAGE_SENSE_ONE_IN, VOLTAGE_SENSE_TWO_IN, POWER_LATCH_STROBE_IN,
                            CLKRUN_N_IN, RING_IN_N};
            sync2_r     <= sync1_r;
            slow_prev_r <= sync2_r[12];
        end
    end

    assign cd1_n_s   = sync2_r[11:10];
    assign cd2_n_s   = sync2_r[9:8];
    assign vs1_s     = sync2_r[7:6];
    assign vs2_s     = sync2_r[5:4];
    assign clkrun_s  = sync2_r[2];
    assign ring_n_s  = sync2_r[1:0];
    assign slow_rise = sync2_r[12] & ~slow_prev_r;
    assign slow_fall = ~sync2_r[12] & slow_prev_r;
    assign smb_mode  = misc3_r[`SPCS_M3_PWRMODE_BIT];
    assign sock      = REG_ADDR[`SPCS_SOCK_SEL_BIT];
    assign off       = REG_ADDR[10:0];

    // Suspend entry gated by the enable bit
    // suspend enable gate
    assign suspended = misc3_r[`SPCS_M3_SUSPEN_BIT] & ~sync2_r[13];

    // ============================================================
    // Misc control 3; power mode strap caught while reset is held
    // power mode strap
    always_ff @(posedge CLOCK)
    begin
        if (CE)
        begin
            if (RST)
            begin
                misc3_r                       <= `SPCS_MISC3_RESET;
                misc3_r[`SPCS_M3_PWRMODE_BIT] <= sync2_r[3];
            end
            else if (REG_WR && REG_ADDR == `SPCS_EXT_BASE + `SPCS_MISC3_IDX)
                misc3_r <= REG_WDATA[7:0];
        end
    end

    // ============================================================
    // Sense interrogation: rest, pull sense one low, pull sense two low
    // detect and sense sampling
    always_ff @(posedge CLOCK)
    begin
        if (CE)
        begin
            if (RST)
            begin
                settle_r <= 8'h00;
                phase_r  <= spcs_pkg::SPCS_PH_REST;
                for (int s = 0; s < 2; s++)
                begin
                    rest_r[s]   <= 4'hf;
                    snap_a_r[s] <= 2'h3;
                    snap_b_r[s] <= 2'h3;
                end
            end
            else if (settle_r != SETTLE_LAST)
                settle_r <= settle_r + 8'h01;
            else
            begin
                settle_r <= 8'h00;
                for (int s = 0; s < 2; s++)
                begin
                    case (phase_r)
                        spcs_pkg::SPCS_PH_REST: rest_r[s]   <= {cd2_n_s[s], cd1_n_s[s], vs2_s[s], vs1_s[s]};
                        spcs_pkg::SPCS_PH_VS1:  snap_a_r[s] <= {cd2_n_s[s], cd1_n_s[s]};
                        default:                snap_b_r[s] <= {cd2_n_s[s], cd1_n_s[s]};
                    endcase
                end
                case (phase_r)
                    spcs_pkg::SPCS_PH_REST: phase_r <= spcs_pkg::SPCS_PH_VS1;
                    spcs_pkg::SPCS_PH_VS1:  phase_r <= spcs_pkg::SPCS_PH_VS2;
                    default:                phase_r <= spcs_pkg::SPCS_PH_REST;
                endcase
            end
        end
    end

    // Decode assumes a low-voltage keyed socket
    // low-voltage key decode
    always_comb
    begin
        for (int s = 0; s < 2; s++)
            info_nxt[s] = decode_card(rest_r[s], snap_a_r[s], snap_b_r[s]);
    end

    // ============================================================
    // Card state, detect-change events and removal power-off
    // detect change event
    always_ff @(posedge CLOCK)
    begin
        if (CE)
        begin
            for (int s = 0; s < 2; s++)
            begin
                if (RST)
                begin
                    info_r[s] <= 8'h00;
                    evt_r[s]  <= 1'b0;
                    mask_r[s] <= 1'b0;
                    vpp_r[s]  <= 2'h0;
                    vcc_r[s]  <= 2'h0;
                end
                else
                begin
                    info_r[s] <= info_nxt[s];
                    // Set wins over a write-one clear
                    if (info_r[s][0] != info_nxt[s][0] || info_nxt[s][0] == 1'b0 && rest_r[s][3:2] != 2'h3)
                        evt_r[s] <= info_r[s][0] != info_nxt[s][0] ? 1'b1 : evt_r[s];
                    if (REG_WR && sock == s[0] && off == `SPCS_EVENT_OFF && REG_WDATA[`SPCS_EVT_DETECT_BIT]
                        && info_r[s][0] == info_nxt[s][0])
                        evt_r[s] <= 1'b0;
                    if (REG_WR && sock == s[0] && off == `SPCS_MASK_OFF)
                        mask_r[s] <= REG_WDATA[`SPCS_EVT_DETECT_BIT];
                    // removal power off; an empty socket keeps no stale supply setting
                    if (!info_nxt[s][0])
                    begin
                        vpp_r[s] <= 2'h0;
                        vcc_r[s] <= 2'h0;
                    end
                    else if (REG_WR && sock == s[0] && off == `SPCS_CONTROL_OFF)
                    begin
                        vpp_r[s] <= REG_WDATA[`SPCS_CTL_VPP_LSB +: 2];
                        vcc_r[s] <= REG_WDATA[`SPCS_CTL_VCC_LSB +: 2];
                    end
                end
            end
        end
    end

    // Power reaches the switch only for a present, supported card
    // power off without card
    always_comb
    begin
        for (int s = 0; s < 2; s++)
            eff_pwr[s] = (info_r[s][0] && !info_r[s][3]) ? {vcc_r[s], vpp_r[s]} : 4'h0;
    end
    assign pwr_word = {eff_pwr[1], eff_pwr[0]};

    // ============================================================
    // Power switch link; a frame starts at a falling reference edge in idle when the word differs from the last sent
    // serial frame and latch
    always_ff @(posedge CLOCK)
    begin
        if (CE)
        begin
            if (RST)
            begin
                link_r <= spcs_pkg::SPCS_IDLE;
                sh_r   <= 18'h3ffff;
                bits_r <= 5'h00;
                sent_r <= 8'h00;
            end
            else
            begin
                case (link_r)
                    spcs_pkg::SPCS_IDLE:
                        if (slow_fall && pwr_word != sent_r)
                        begin
                            sent_r <= pwr_word;
                            if (smb_mode)
                            begin
                                sh_r   <= {`SPCS_SMB_ADDR, 1'b0, 1'b1, pwr_word, 1'b1};
                                bits_r <= `SPCS_SMB_BITS;
                                link_r <= spcs_pkg::SPCS_START;
                            end
                            else
                            begin
                                sh_r   <= {pwr_word, 10'h3ff};
                                bits_r <= `SPCS_SERIAL_BITS;
                                link_r <= spcs_pkg::SPCS_SHIFT;
                            end
                        end
                    spcs_pkg::SPCS_START:
                        if (slow_fall)
                            link_r <= spcs_pkg::SPCS_SHIFT;
                    spcs_pkg::SPCS_SHIFT:
                        if (slow_fall)
                        begin
                            if (bits_r == 5'h01)
                                link_r <= smb_mode ? spcs_pkg::SPCS_STOP : spcs_pkg::SPCS_LATCH;
                            else
                            begin
                                sh_r   <= {sh_r[16:0], 1'b1};
                                bits_r <= bits_r - 5'h01;
                            end
                        end
                    spcs_pkg::SPCS_STOP:
                        if (slow_rise)
                            link_r <= spcs_pkg::SPCS_IDLE;
                    spcs_pkg::SPCS_LATCH:
                        if (slow_fall)
                            link_r <= spcs_pkg::SPCS_IDLE;
                    default:
                        link_r <= spcs_pkg::SPCS_IDLE;
                endcase
            end
        end
    end

    // Line levels; data trails the clock by one cycle
    always_ff @(posedge CLOCK)
    begin
        if (CE)
        begin
            if (RST)
            begin
                line_data_r  <= 1'b1;
                line_clk_r   <= 1'b1;
                line_latch_r <= 1'b0;
            end
            else
            begin
                line_data_r  <= (link_r == spcs_pkg::SPCS_SHIFT) ? sh_r[17] : (link_r == spcs_pkg::SPCS_IDLE);
                line_clk_r   <= (link_r == spcs_pkg::SPCS_SHIFT || link_r == spcs_pkg::SPCS_STOP) ? sync2_r[12]
                                : 1'b1;
                line_latch_r <= (link_r == spcs_pkg::SPCS_LATCH);
            end
        end
    end

    // ============================================================
    // Register read port
    // present state report
    always_ff @(posedge CLOCK)
    begin
        if (CE)
        begin
            if (RST)
                REG_RDATA <= 32'h0;
            else if (REG_RD)
            begin
                REG_RDATA <= 32'h0;
                if (REG_ADDR == `SPCS_EXT_BASE + `SPCS_MISC3_IDX)
                    REG_RDATA <= {24'h0, misc3_r};
                else if (off == `SPCS_EVENT_OFF)
                    REG_RDATA[`SPCS_EVT_DETECT_BIT] <= evt_r[sock];
                else if (off == `SPCS_MASK_OFF)
                    REG_RDATA[`SPCS_EVT_DETECT_BIT] <= mask_r[sock];
                else if (off == `SPCS_PRESENT_OFF)
                begin
                    REG_RDATA[`SPCS_PS_CD1_BIT]     <= rest_r[sock][2];
                    REG_RDATA[`SPCS_PS_CD2_BIT]     <= rest_r[sock][3];
                    REG_RDATA[`SPCS_PS_PWRCYC_BIT]  <= eff_pwr[sock] != 4'h0;
                    REG_RDATA[`SPCS_PS_C16_BIT]     <= info_r[sock][1];
                    REG_RDATA[`SPCS_PS_CB_BIT]      <= info_r[sock][2];
                    REG_RDATA[`SPCS_PS_NOTCARD_BIT] <= info_r[sock][3];
                    REG_RDATA[`SPCS_PS_5V_BIT]      <= info_r[sock][4];
                    REG_RDATA[`SPCS_PS_3V_BIT]      <= info_r[sock][5];
                    REG_RDATA[`SPCS_PS_XV_BIT]      <= info_r[sock][6];
                    REG_RDATA[`SPCS_PS_YV_BIT]      <= info_r[sock][7];
                end
                else if (off == `SPCS_CONTROL_OFF)
                    REG_RDATA <= 32'({vcc_r[sock], 2'h0, vpp_r[sock]});
            end
        end
    end

    // ============================================================
    // Pin drive; suspend floats everything but bus request
    // removal interrupt
    assign irq_req = evt_r & mask_r;

    always_ff @(posedge CLOCK)
    begin
        if (CE)
        begin
            BUS_REQUEST_N_OUT     <= 1'b1;
            BUS_REQUEST_N_OE      <= 1'b1;
            VOLTAGE_SENSE_ONE_OUT <= 2'h0;
            VOLTAGE_SENSE_TWO_OUT <= 2'h0;
            INTA_N_OUT            <= 1'b0;
            INTB_N_OUT            <= 1'b0;
            CLKRUN_N_OUT          <= 1'b0;
            RING_INDICATE_OUT_N   <= 1'b0;
            VOLTAGE_SENSE_ONE_OE  <= {2{~suspended && phase_r == spcs_pkg::SPCS_PH_VS1 && !RST}};
            VOLTAGE_SENSE_TWO_OE  <= {2{~suspended && phase_r == spcs_pkg::SPCS_PH_VS2 && !RST}};
            POWER_SERIAL_DATA_OUT <= smb_mode ? 1'b0 : line_data_r;
            POWER_SERIAL_DATA_OE  <= ~suspended && !RST && (smb_mode ? ~line_data_r : 1'b1);
            POWER_LATCH_STROBE_OUT <= smb_mode ? 1'b0 : line_latch_r;
            POWER_LATCH_STROBE_OE  <= ~suspended && !RST && (smb_mode ? ~line_clk_r : 1'b1);
            INTA_N_OE        <= ~suspended && !RST && misc3_r[1:0] == `SPCS_INT_MODE_PCI && irq_req[0];
            INTB_N_OE        <= ~suspended && !RST && misc3_r[1:0] == `SPCS_INT_MODE_PCI && irq_req[1];
            RING_INDICATE_OE <= ~suspended && !RST && ring_n_s != 2'h3;
            CLKRUN_N_OE <= ~suspended && !RST && misc3_r[1:0] != `SPCS_INT_MODE_PCI && |irq_req && clkrun_s;
            ISA_IRQ_OUT <= misc3_r[1:0] != `SPCS_INT_MODE_PCI && |irq_req && !clkrun_s;
            ISA_IRQ_OE  <= ~suspended && !RST && misc3_r[1:0] != `SPCS_INT_MODE_PCI;
        end
    end

endmodule

// file: tb/spcs_sva.sv
`timescale 1ns/10ps
// ============================================================
// Port checker
module spcs_sva
(
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic [11:0] REG_ADDR,
    input wire logic        REG_RD,
    input wire logic        REG_WR,
    input wire logic [31:0] REG_WDATA,
    input wire logic [31:0] REG_RDATA,
    input wire logic        SUSPEND_REQUEST_PIN_N,
    input wire logic [1:0]  RING_IN_N,
    input wire logic        RING_INDICATE_OE,
    input wire logic        POWER_LATCH_STROBE_OUT,
    input wire logic [1:0]  VOLTAGE_SENSE_ONE_OE,
    input wire logic [1:0]  VOLTAGE_SENSE_TWO_OE,
    input wire logic        BUS_REQUEST_N_OUT,
    input wire logic        BUS_REQUEST_N_OE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    property p_rst;
        disable iff (1'b0) RST |=> BUS_REQUEST_N_OE && REG_RDATA == 32'h0 && VOLTAGE_SENSE_ONE_OE == 2'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset outputs wrong");
    property p_busreq;
        BUS_REQUEST_N_OE && BUS_REQUEST_N_OUT;
    endproperty
    a_busreq: assert property (p_busreq) else $error("bus request not high");
    property p_hold;
        !REG_RD |=> $stable(REG_RDATA);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unmap;
        REG_RD && REG_ADDR == 12'h0f0 |=> REG_RDATA == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_misc;
        REG_WR && REG_ADDR == 12'h925 ##1 !REG_WR ##1 REG_RD && REG_ADDR == 12'h925 |=>
            REG_RDATA[7:0] == $past(REG_WDATA[7:0], 3);
    endproperty
    a_misc: assert property (p_misc) else $error("control three readback");
    property p_latch;
        $rose(POWER_LATCH_STROBE_OUT) |=> POWER_LATCH_STROBE_OUT [*8];
    endproperty
    a_latch: assert property (p_latch) else $error("latch strobe short");
    property p_sense;
        $rose(VOLTAGE_SENSE_ONE_OE[0]) |-> !VOLTAGE_SENSE_TWO_OE[0] [*8];
    endproperty
    a_sense: assert property (p_sense) else $error("both senses pulled");
    property p_ring;
        $fell(&RING_IN_N) && SUSPEND_REQUEST_PIN_N |-> ##[0:4] RING_INDICATE_OE;
    endproperty
    a_ring: assert property (p_ring) else $error("ring not shown");
endmodule

// file: tb/spcs_switch_model.sv
`timescale 1ns/10ps
// ============================================================
// Serial socket power switch
module spcs_switch_model
(
    input  wire logic       sclk,
    input  wire logic       power_serial_data,
    input  wire logic       latch,
    output logic      [7:0] word
);
    logic [7:0] shift_r;
    initial word = 8'h00;
    always @(posedge sclk) shift_r <= {shift_r[6:0], power_serial_data};
    always @(posedge latch) word <= shift_r;
endmodule

// file: tb/socket_power_card_sense_tb.sv
`timescale 1ns/10ps
// ============================================================
// Bench
module socket_power_card_sense_tb;
    logic        CLOCK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, SUSPEND_REQUEST_PIN_N = 1'b1, SLOW_CLK = 1'b0;
    logic [11:0] REG_ADDR = 12'h000;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA, d;
    logic [1:0]  CARD_DETECT_ONE_N = 2'h3, CARD_DETECT_TWO_N = 2'h3, RING_IN_N = 2'h3, gnd1 = 2'h0, gnd2 = 2'h0;
    logic [1:0]  VOLTAGE_SENSE_ONE_OUT, VOLTAGE_SENSE_ONE_OE, VOLTAGE_SENSE_TWO_OUT, VOLTAGE_SENSE_TWO_OE;
    logic        POWER_SERIAL_DATA_OUT, POWER_SERIAL_DATA_OE, POWER_LATCH_STROBE_OUT, POWER_LATCH_STROBE_OE;
    logic        CLKRUN_N_OUT, CLKRUN_N_OE, INTA_N_OUT, INTA_N_OE, INTB_N_OUT, INTB_N_OE, ISA_IRQ_OUT, ISA_IRQ_OE;
    logic        RING_INDICATE_OUT_N, RING_INDICATE_OE, BUS_REQUEST_N_OUT, BUS_REQUEST_N_OE;
    logic [7:0]  word;
    int          num_errors = 0, n_checks = 0, n_pull = 0;
    wire         CE = 1'b1;
    logic        CLKRUN_N_IN = 1'b0;
    // Sense pins pulled up, grounded by the card or the device
    wire  [1:0]  VOLTAGE_SENSE_ONE_IN = ~(VOLTAGE_SENSE_ONE_OE | gnd1);
    wire  [1:0]  VOLTAGE_SENSE_TWO_IN = ~(VOLTAGE_SENSE_TWO_OE | gnd2);
    wire         POWER_LATCH_STROBE_IN = POWER_LATCH_STROBE_OE & POWER_LATCH_STROBE_OUT;
    spcs_top spcs_top_i (.*);
    spcs_switch_model spcs_switch_model_i (.sclk(SLOW_CLK), .power_serial_data(POWER_SERIAL_DATA_OUT),
        .latch(POWER_LATCH_STROBE_OUT), .word(word));
    // Clocks
    always #2.5 CLOCK = ~CLOCK;
    always #24 SLOW_CLK = ~SLOW_CLK; // free-running reference
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge CLOCK);
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
        REG_ADDR = a;
        REG_WDATA = v;
        REG_WR = 1'b1;
        @(negedge CLOCK);
        REG_WR = 1'b0;
        @(negedge CLOCK);
    endtask
    task automatic rd_reg(input logic [11:0] a);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(negedge CLOCK);
        REG_RD = 1'b0;
        d = REG_RDATA;
        @(negedge CLOCK);
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        idle(20);
        RST = 1'b0;
        rd_reg(12'h925); check(d, 32'h03);
        rd_reg(12'h0f0); check(d, 32'h0);
        wr_reg(12'h010, 32'h10); idle(300); check({24'h0, word}, 32'h0);
        rd_reg(12'h010); check(d, 32'h0);
        wr_reg(12'h010, 32'h0);
        RING_IN_N = 2'h2; idle(5); check({31'h0, RING_INDICATE_OE}, 32'h1);
        RING_IN_N = 2'h3;
        CARD_DETECT_ONE_N = 2'h2; CARD_DETECT_TWO_N = 2'h2; idle(1300);
        rd_reg(12'h008); check(d & 32'h3c18, 32'h0410);
        rd_reg(12'h000); check(d & 32'h2, 32'h2);
        wr_reg(12'h004, 32'h2); idle(4); check({31'h0, INTA_N_OE}, 32'h1);
        wr_reg(12'h000, 32'h2); idle(4); check({31'h0, INTA_N_OE}, 32'h0);
        wr_reg(12'h010, 32'h10); idle(300); check({24'h0, word}, 32'h04);
        rd_reg(12'h008); check(d & 32'h8, 32'h8);
        CARD_DETECT_ONE_N = 2'h3; CARD_DETECT_TWO_N = 2'h3; idle(1300);
        check({24'h0, word}, 32'h0);
        check({31'h0, INTA_N_OE}, 32'h1);
        wr_reg(12'h000, 32'h2);
        CARD_DETECT_ONE_N = 2'h1; CARD_DETECT_TWO_N = 2'h1; gnd1 = 2'h2; gnd2 = 2'h2; idle(1300);
        rd_reg(12'h808); check(d & 32'h3c18, 32'h1810);
        SUSPEND_REQUEST_PIN_N = 1'b0; idle(10); check({31'h0, POWER_SERIAL_DATA_OE}, 32'h1);
        SUSPEND_REQUEST_PIN_N = 1'b1; idle(10);
        wr_reg(12'h925, 32'h13); rd_reg(12'h925); check(d, 32'h13);
        SUSPEND_REQUEST_PIN_N = 1'b0; idle(10);
        check({27'h0, BUS_REQUEST_N_OE, POWER_SERIAL_DATA_OE, INTA_N_OE, VOLTAGE_SENSE_ONE_OE}, 32'h10);
        SUSPEND_REQUEST_PIN_N = 1'b1; idle(10);
        rd_reg(12'h808); check(d & 32'h3c18, 32'h1810);
        rd_reg(12'h925); check(d, 32'h13);
        wr_reg(12'h804, 32'h2); idle(4); check({31'h0, INTB_N_OE}, 32'h1);
        CLKRUN_N_IN = 1'b1; wr_reg(12'h925, 32'h0); idle(4);
        check({28'h0, CLKRUN_N_OUT, CLKRUN_N_OE, ISA_IRQ_OE, ISA_IRQ_OUT}, 32'h6);
        CLKRUN_N_IN = 1'b0; idle(4);
        check({28'h0, CLKRUN_N_OUT, CLKRUN_N_OE, ISA_IRQ_OE, ISA_IRQ_OUT}, 32'h3);
        wr_reg(12'h925, 32'h4); wr_reg(12'h810, 32'h10);
        repeat (300) @(negedge CLOCK) n_pull += POWER_SERIAL_DATA_OE;
        check({31'h0, n_pull != 0}, 32'h1);
        check({22'h0, word, POWER_SERIAL_DATA_OE, POWER_LATCH_STROBE_OE}, 32'h0);
        rd_reg(12'h808); check(d & 32'h8, 32'h8);
        report_and_stop();
    end
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge CLOCK);
        num_errors++;
        report_and_stop();
    end
endmodule
bind spcs_top spcs_sva spcs_sva_i (.*);
